/* rtl/ddioc_pkg.sv */
/*
  Shared constants for the drive digital I/O conditioning block: register
  offsets, field positions, reset values, delay limits and function codes.
  Assumes a single 100 MHz clock and an APB register bus with 32-bit data.
*/
package ddioc_pkg;

  // Channel counts and delay width.
  localparam int NUM_OUT = 2;
  localparam int NUM_IN = 10;
  localparam int DLY_W = 16;

  // Clock rate and millisecond timebase.
  localparam int CLK_HZ = 100000000;
  localparam int TICK_TIME_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int TICK_W = 17;

  // Delay limits and reset values in milliseconds, and the active level reset value.
  localparam logic [15:0] ACT_MAX_MS = 16'hEA60;
  localparam logic [15:0] ACT_DEF_MS = 16'h0000;
  localparam logic [15:0] HOLD_MAX_MS = 16'h270F;
  localparam logic [15:0] HOLD_DEF_MS = 16'h0000;
  localparam logic [7:0] IN_MAX_MS = 8'hC8;
  localparam logic [7:0] IN_DEF_MS = 8'h05;
  localparam logic POL_DEF = 1'b1;

  // Output assignment classes that decide which settings are locked.
  typedef enum logic [1:0] {
    CLS_GENERAL,
    CLS_FAULT,
    CLS_BRAKE,
    CLS_MAINS
  } ddioc_cls_t;

  // Cabinet input function codes.
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_FREEWHEEL = 5'h01;
  localparam logic [4:0] FN_LOW_LAST = 5'h0E;
  localparam logic [4:0] FN_HIGH_LAST = 5'h12;
  localparam int FN_COUNT = 19;

  // Register byte offsets.
  localparam logic [7:0] OFS_OUT_CFG = 8'h00;
  localparam logic [7:0] OFS_OUT_ACT = 8'h04;
  localparam logic [7:0] OFS_OUT_HOLD = 8'h08;
  localparam logic [7:0] OFS_OUT_STRIDE = 8'h0C;
  localparam logic [7:0] OFS_IN_CFG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h48;

  // Field positions.
  localparam int CFG_CLS_LSB = 0;
  localparam int CFG_POL_BIT = 8;
  localparam int IN_LOW_LSB = 0;
  localparam int IN_HIGH_LSB = 8;
  localparam int IN_DLY_LSB = 16;
  localparam int ST_INFO_LSB = 0;
  localparam int ST_STATE_LSB = 2;
  localparam int ST_IN_LSB = 8;

endpackage

/* rtl/ddioc_sync.sv */
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is independent; no multi-bit coherency is promised.
*/
`timescale 1ns/100ps
module ddioc_sync #(
  parameter int W = 10
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin side and clocked side.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

/* rtl/ddioc_delay.sv */
/*
  Level delay: the output follows the input only after the input has held
  its new level for the programmed number of millisecond ticks.
  Assumes a one-cycle tick pulse once per millisecond on the same clock.
*/
`timescale 1ns/100ps
module ddioc_delay
  import ddioc_pkg::*;
(
  // Clock, reset and timebase.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // Level and delays.
  input wire logic level_in,
  input wire logic [DLY_W-1:0] rise_ms,
  input wire logic [DLY_W-1:0] fall_ms,
  output logic level_out
);

  logic [DLY_W-1:0] elapsed;
  logic [DLY_W-1:0] target;
  logic pending;
  logic expired;

  assign target = level_in ? rise_ms : fall_ms;
  assign pending = level_in != level_out;
  assign expired = elapsed >= target;

  // cancel on revert.
  // Counts ticks while a change is pending; a revert clears the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= '0;
    end else if (!pending || expired) begin
      elapsed <= '0;
    end else if (tick) begin
      elapsed <= elapsed + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b0;
    end else if (pending && expired) begin
      level_out <= level_in;
    end
  end

endmodule

/* rtl/ddioc_top.sv */
/*
  Drive digital I/O conditioning: two extension outputs with activation
  delay, holding delay and active level, and ten cabinet inputs with a
  processing delay and low-level and high-level function assignments.
  Assumes an APB master on pclk, output information from logic on pclk,
  and cabinet pins asynchronous to pclk.
  The millisecond timebase is derived from pclk. TICK_CYCLES may be lowered
  for simulation, which shortens every delay in proportion.
  Function requests are levels, and the drive logic decides what each one does.
*/
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Contract
// - Output changes after activation delay when true
// - Fault or mains class forces activation delay zero
// - Active level chooses output polarity, default one
// - Fault, brake, mains lock active level one
// - Output changes after holding delay when false
// - Fault, brake, mains force holding delay zero
// - Cabinet input acts after its delay
// - Low assignment from fixed function set
// - High set adds four, drops freewheel stop
// - All cabinet inputs share identical behaviour
module ddioc_top
  import ddioc_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Output information from the drive logic.
  input wire logic out_info_first,
  input wire logic out_info_second,
  // Extension output pins.
  output logic ext_output_first,
  output logic ext_output_second,
  // Cabinet input pins.
  input wire logic cabinet_input_first,
  input wire logic cabinet_input_second,
  input wire logic cabinet_input_third,
  input wire logic cabinet_input_fourth,
  input wire logic [5:0] cabinet_input_rest,
  // Function requests, one bit per function code.
  output logic [FN_COUNT-1:0] func_req
);

  // Configuration state.
  // Delays are held in ms, and the input delays fit in eight bits.
  ddioc_cls_t out_cls [NUM_OUT];
  logic out_pol [NUM_OUT];
  logic [DLY_W-1:0] out_act [NUM_OUT];
  logic [DLY_W-1:0] out_hold [NUM_OUT];
  logic [4:0] in_low [NUM_IN];
  logic [4:0] in_high [NUM_IN];
  logic [7:0] in_dly [NUM_IN];

  // Datapath state.
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [NUM_OUT-1:0] out_info;
  logic [NUM_OUT-1:0] out_state;
  logic [NUM_IN-1:0] pin_raw;
  logic [NUM_IN-1:0] pin_sync;
  logic [NUM_IN-1:0] in_filt;
  logic [FN_COUNT-1:0] next_func_req;

  // Each register is one aligned 32-bit word at a byte address.
  // Output c configuration sits at 0x00 plus 0x0C times c.
  // Its class is in bits 1 to 0 and its active level in bit 8.
  // Output c activation delay in ms sits at 0x04 plus 0x0C times c.
  // Output c holding delay in ms sits at 0x08 plus 0x0C times c.
  // Cabinet input i configuration sits at 0x20 plus 4 times i.
  // Its low code is in bits 4 to 0 and its high code in bits 12 to 8.
  // Its delay in ms is in bits 23 to 16.
  // Status at 0x48 is read only, with the information in bits 1 to 0.
  // Delayed output states are in bits 3 to 2 and filtered inputs in bits 17 to 8.
  // Any other address answers with an error and changes nothing.
  // Dropped delays and replaced codes raise no error.
  // APB decode.
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_val;

  assign out_info = {out_info_second, out_info_first};
  assign pin_raw = {cabinet_input_rest, cabinet_input_fourth, cabinet_input_third,
                    cabinet_input_second, cabinet_input_first};

  // Millisecond timebase.
  // The tick runs free, so the first millisecond of a delay may be short.
  // A delay of N ms therefore lasts between N-1 and N ms, plus two cycles.
  // A shared tick keeps one counter for all twelve channels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // APB handshake: access phases last two cycles, writes land on the pready edge.
  // Registering pready keeps the read mux off the answer path, at the cost of a
  // fixed wait state on every transfer.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Read mux and address check.
  // An unmatched address leaves addr_ok low, which becomes an error answer.
  always_comb begin
    rd_val = 32'h00000000;
    addr_ok = 1'b0;
    for (int c = 0; c < NUM_OUT; c++) begin
      if (paddr == 8'(OFS_OUT_CFG + OFS_OUT_STRIDE * c)) begin
        addr_ok = 1'b1;
        rd_val[CFG_CLS_LSB +: 2] = out_cls[c];
        rd_val[CFG_POL_BIT] = out_pol[c];
      end
      if (paddr == 8'(OFS_OUT_ACT + OFS_OUT_STRIDE * c)) begin
        addr_ok = 1'b1;
        rd_val[DLY_W-1:0] = out_act[c];
      end
      if (paddr == 8'(OFS_OUT_HOLD + OFS_OUT_STRIDE * c)) begin
        addr_ok = 1'b1;
        rd_val[DLY_W-1:0] = out_hold[c];
      end
    end
    for (int i = 0; i < NUM_IN; i++) begin
      if (paddr == 8'(OFS_IN_CFG + 4 * i)) begin
        addr_ok = 1'b1;
        rd_val[IN_LOW_LSB +: 5] = in_low[i];
        rd_val[IN_HIGH_LSB +: 5] = in_high[i];
        rd_val[IN_DLY_LSB +: 8] = in_dly[i];
      end
    end
    if (paddr == OFS_STATUS) begin
      addr_ok = 1'b1;
      rd_val[ST_INFO_LSB +: NUM_OUT] = out_info;
      rd_val[ST_STATE_LSB +: NUM_OUT] = out_state;
      rd_val[ST_IN_LSB +: NUM_IN] = in_filt;
    end
  end

  // Read data and error flag, presented with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata <= rd_en ? rd_val : 32'h00000000;
      pslverr <= !addr_ok;
    end else begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Output configuration registers.
  // A class write applies its locks at once, so a locked setting never shows a
  // stale value. Delay writes are checked against the class already stored,
  // and out-of-range values are dropped so that the previous delay stays in force.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_OUT; c++) begin
        out_cls[c] <= CLS_GENERAL;
        out_pol[c] <= POL_DEF;
        out_act[c] <= ACT_DEF_MS;
        out_hold[c] <= HOLD_DEF_MS;
      end
    end else if (wr_en) begin
      for (int c = 0; c < NUM_OUT; c++) begin
        if (paddr == 8'(OFS_OUT_CFG + OFS_OUT_STRIDE * c)) begin
          out_cls[c] <= ddioc_cls_t'(pwdata[CFG_CLS_LSB +: 2]);
          if (ddioc_cls_t'(pwdata[CFG_CLS_LSB +: 2]) != CLS_GENERAL) begin
            out_pol[c] <= 1'b1;
          end else begin
            out_pol[c] <= pwdata[CFG_POL_BIT];
          end
          if (ddioc_cls_t'(pwdata[CFG_CLS_LSB +: 2]) == CLS_FAULT ||
              ddioc_cls_t'(pwdata[CFG_CLS_LSB +: 2]) == CLS_MAINS) begin
            out_act[c] <= 16'h0000;
          end
          if (ddioc_cls_t'(pwdata[CFG_CLS_LSB +: 2]) != CLS_GENERAL) begin
            out_hold[c] <= 16'h0000;
          end
        end
        if (paddr == 8'(OFS_OUT_ACT + OFS_OUT_STRIDE * c) &&
            out_cls[c] != CLS_FAULT && out_cls[c] != CLS_MAINS &&
            pwdata[DLY_W-1:0] <= ACT_MAX_MS) begin
          out_act[c] <= pwdata[DLY_W-1:0];
        end
        if (paddr == 8'(OFS_OUT_HOLD + OFS_OUT_STRIDE * c) &&
            out_cls[c] == CLS_GENERAL && pwdata[DLY_W-1:0] <= HOLD_MAX_MS) begin
          out_hold[c] <= pwdata[DLY_W-1:0];
        end
      end
    end
  end

  // Cabinet input configuration registers; out-of-set codes fall back to none.
  // Codes 0 to 3 are none, freewheel stop, external error and drive lock.
  // Codes 4 to 7 are monitoring circuits A to D, 8 to 10 cabinet circuits A to C.
  // Codes 11 and 12 are motor windings A and B, 13 and 14 motor bearings A and B.
  // Codes 15 to 18 are forced local, fault reset, product restart and mains control.
  // Low assignments take codes 0 to 14, and high assignments take 0 and 2 to 18.
  // Delays above the limit are dropped and the old delay is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_low[i] <= FN_NONE;
        in_high[i] <= FN_NONE;
        in_dly[i] <= IN_DEF_MS;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (paddr == 8'(OFS_IN_CFG + 4 * i)) begin
          in_low[i] <= (pwdata[IN_LOW_LSB +: 5] <= FN_LOW_LAST) ?
                       pwdata[IN_LOW_LSB +: 5] : FN_NONE;
          in_high[i] <= (pwdata[IN_HIGH_LSB +: 5] <= FN_HIGH_LAST &&
                         pwdata[IN_HIGH_LSB +: 5] != FN_FREEWHEEL) ?
                        pwdata[IN_HIGH_LSB +: 5] : FN_NONE;
          if (pwdata[IN_DLY_LSB +: 8] <= IN_MAX_MS) begin
            in_dly[i] <= pwdata[IN_DLY_LSB +: 8];
          end
        end
      end
    end
  end

  // Output channels: activation delay on rising information, holding on falling.
  // The delay works on the information before polarity, so the active level
  // only inverts the pin and never changes the timing.
  for (genvar c = 0; c < NUM_OUT; c++) begin : g_out
    ddioc_delay u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .level_in(out_info[c]),
      .rise_ms(out_act[c]),
      .fall_ms(out_hold[c]),
      .level_out(out_state[c])
    );
  end

  // Pins are registered after polarity so that every pin comes from a flip-flop.
  // This adds one cycle behind the delayed state.
  // active level polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_output_first <= 1'b0;
      ext_output_second <= 1'b0;
    end else begin
      ext_output_first <= out_pol[0] ? out_state[0] : !out_state[0];
      ext_output_second <= out_pol[1] ? out_state[1] : !out_state[1];
    end
  end

  // Cabinet pins are synchronised before filtering.
  // Each bit is synchronised alone, since the filter needs no coherency across bits.
  ddioc_sync #(
    .W(NUM_IN)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  // Both edges of an input see the same delay. The filtered level starts low,
  // so low assignments act from reset until a high pin has passed its delay.
  // identical input channels.
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    ddioc_delay u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .level_in(pin_sync[i]),
      .rise_ms({8'h00, in_dly[i]}),
      .fall_ms({8'h00, in_dly[i]}),
      .level_out(in_filt[i])
    );
  end

  // Several inputs may ask for the same function, and their requests are merged.
  // Code none maps to bit zero, which is cleared after the loop.
  // low assignment acts.
  always_comb begin
    next_func_req = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (in_filt[i]) begin
        next_func_req[in_high[i]] = 1'b1;
      end else begin
        next_func_req[in_low[i]] = 1'b1;
      end
    end
    next_func_req[FN_NONE] = 1'b0;
  end

  // Registered function requests.
  // Registering them keeps decode glitches off the outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_req <= '0;
    end else begin
      func_req <= next_func_req;
    end
  end

endmodule

/* dv/ddioc_top_monitor.sv */
/*
  Checker for the APB answer and the request outputs of the conditioning block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module ddioc_top_monitor
  import ddioc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Function requests.
  input wire logic [FN_COUNT-1:0] func_req
);
  // All checks share the bus clock and its reset.
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The slave answers one cycle into the access phase, once per transfer.
  ready_timing_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready [*2])
    else $error("ready too long");
  ready_access_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside access");
  // Read data and error only stand in the answer cycle.
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_qual_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without answer");
  err_unmapped_a: assert property (pready && paddr > OFS_STATUS |-> pslverr)
    else $error("unmapped not refused");
  err_mapped_a: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped refused");
  // Function code none never raises a request.
  none_code_a: assert property (func_req[0] == 1'b0)
    else $error("none code requested");
endmodule

bind ddioc_top ddioc_top_monitor mon_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .func_req(func_req)
);

/* dv/ddioc_field.sv */
/*
  Field side model: contacts wired to the cabinet input terminals.
  Assumes the bench commands each contact level; contacts do not bounce.
*/
`timescale 1ns/100ps
module ddioc_field (
  // Commanded contact levels.
  input wire logic [9:0] contact,
  // Cabinet input pins.
  output logic pin_first,
  output logic pin_second,
  output logic pin_third,
  output logic pin_fourth,
  output logic [5:0] pin_rest
);
  // Each contact drives its own pin directly, as a closed or open switch.
  assign pin_first = contact[0];
  assign pin_second = contact[1];
  assign pin_third = contact[2];
  assign pin_fourth = contact[3];
  assign pin_rest = contact[9:4];
endmodule

/* dv/ddioc_tb_top.sv */
/*
  Self-checking bench for the conditioning block: register table, delays and inputs.
  Assumes a shortened millisecond tick of 10 cycles on a 100 MHz clock.
*/
`timescale 1ns/100ps
module ddioc_tb_top;
  import ddioc_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic e;} ddioc_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic out_info_first = 1'b0;
  logic out_info_second = 1'b0;
  logic ext_output_first;
  logic ext_output_second;
  logic [9:0] lvl = 10'h000;
  logic pin1, pin2, pin3, pin4;
  logic [5:0] pin_rest;
  logic [FN_COUNT-1:0] func_req;
  logic [31:0] q;
  logic e;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  // Reads hold the expected value in d; writes hold the data.
  ddioc_row_t rows [] = '{
    '{8'h00, 1'b0, 32'h100, 1'b0},
    '{8'h04, 1'b0, 32'h0, 1'b0},
    '{8'h08, 1'b0, 32'h0, 1'b0},
    '{8'h20, 1'b0, 32'h50000, 1'b0},
    '{8'h44, 1'b0, 32'h50000, 1'b0},
    '{8'h04, 1'b1, 32'hEA60, 1'b0},
    '{8'h04, 1'b1, 32'hEA61, 1'b0},
    '{8'h04, 1'b0, 32'hEA60, 1'b0},
    '{8'h08, 1'b1, 32'h270F, 1'b0},
    '{8'h08, 1'b1, 32'h2710, 1'b0},
    '{8'h08, 1'b0, 32'h270F, 1'b0},
    '{8'h20, 1'b1, 32'hC8120E, 1'b0},
    '{8'h20, 1'b0, 32'hC8120E, 1'b0},
    '{8'h24, 1'b1, 32'hC80101, 1'b0},
    '{8'h24, 1'b0, 32'hC80001, 1'b0},
    '{8'h24, 1'b1, 32'hC8000F, 1'b0},
    '{8'h24, 1'b0, 32'hC80000, 1'b0},
    '{8'h00, 1'b1, 32'h001, 1'b0},
    '{8'h00, 1'b0, 32'h101, 1'b0},
    '{8'h08, 1'b0, 32'h0, 1'b0},
    '{8'h04, 1'b1, 32'h5, 1'b0},
    '{8'h04, 1'b0, 32'h0, 1'b0},
    '{8'h0C, 1'b1, 32'h002, 1'b0},
    '{8'h10, 1'b1, 32'h7, 1'b0},
    '{8'h10, 1'b0, 32'h7, 1'b0},
    '{8'h14, 1'b1, 32'h3, 1'b0},
    '{8'h14, 1'b0, 32'h0, 1'b0},
    '{8'h0C, 1'b1, 32'h003, 1'b0},
    '{8'h10, 1'b0, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'h5, 1'b0},
    '{8'h10, 1'b0, 32'h0, 1'b0},
    '{8'h0C, 1'b0, 32'h103, 1'b0},
    '{8'h18, 1'b0, 32'h0, 1'b1},
    '{8'h4C, 1'b0, 32'h0, 1'b1}
  };

  ddioc_top #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_info_first(out_info_first),
    .out_info_second(out_info_second), .ext_output_first(ext_output_first),
    .ext_output_second(ext_output_second), .cabinet_input_first(pin1),
    .cabinet_input_second(pin2), .cabinet_input_third(pin3), .cabinet_input_fourth(pin4),
    .cabinet_input_rest(pin_rest), .func_req(func_req));
  ddioc_field field_u (.contact(lvl), .pin_first(pin1), .pin_second(pin2), .pin_third(pin3),
    .pin_fourth(pin4), .pin_rest(pin_rest));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("Errors %0d in %0d checks", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] rq, output logic re);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, q, e);
    chk(q, x);
  endtask

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Register table rows, refusals included.
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d, q, e);
      if (!rows[i].w) chk(q, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
    end
    // A second reset restores defaults and clears the pins.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(ext_output_first), 32'h0);
    chk(32'(func_req), 32'h0);
    presetn <= 1'b1;
    rd(8'h00, 32'h100);
    // Activation delay of 3 ms and holding delay of 2 ms on the first output.
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h2);
    out_info_first <= 1'b1;
    repeat (15) @(posedge pclk);
    chk(32'(ext_output_first), 32'h0);
    repeat (20) @(posedge pclk);
    chk(32'(ext_output_first), 32'h1);
    out_info_first <= 1'b0;
    repeat (5) @(posedge pclk);
    out_info_first <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(ext_output_first), 32'h1);
    out_info_first <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(32'(ext_output_first), 32'h1);
    repeat (25) @(posedge pclk);
    chk(32'(ext_output_first), 32'h0);
    wr(8'h00, 32'h000);
    repeat (3) @(posedge pclk);
    chk(32'(ext_output_first), 32'h1);
    // Fault class on the second output clears its delays, so it switches at once both ways.
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h2);
    wr(8'h0C, 32'h001);
    out_info_second <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(ext_output_second), 32'h1);
    out_info_second <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(ext_output_second), 32'h0);
    // First cabinet input: error low, reset high, 2 ms; last: lock low, mains high, 0 ms.
    wr(8'h20, 32'h21002);
    wr(8'h44, 32'h1203);
    repeat (80) @(posedge pclk);
    chk(32'(func_req), 32'hC);
    lvl[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(func_req), 32'hC);
    repeat (30) @(posedge pclk);
    chk(32'(func_req), 32'h10008);
    lvl[9] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(func_req), 32'h50000);
    lvl[0] <= 1'b0;
    repeat (5) @(posedge pclk);
    lvl[0] <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(func_req), 32'h50000);
    rd(8'h48, 32'h20100);
    stop_test();
  end
endmodule
